// [design/temp_alarm_pkg.sv]
// shared constants for the temperature status-flag block
package temp_alarm_pkg;
   // ---------------------------------------------------------------
   // smbus target
   // ---------------------------------------------------------------
   localparam logic [6:0] TARGET_ADDR = 7'h4D; // 1001101, sits in A7..A1
   localparam logic [7:0] CMD_OVERTEMP_STATUS = 8'h01;
   localparam logic [7:0] CMD_DIODE_FAULT_STATUS = 8'h02;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ---------------------------------------------------------------
   // register layout and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OVERTEMP_STATUS_RST = 8'h00;
   localparam logic [7:0] DIODE_FAULT_STATUS_RST = 8'h00;
   localparam int OT_BIT_CH1 = 0;
   localparam int OT_BIT_CH4 = 3;
   localparam int OT_BIT_CH5 = 4;
   localparam int OT_BIT_CH6 = 5;
   localparam int FAULT_BIT_FIRST = 1; // channel n at bit n
   localparam int NUM_REMOTE = 6;
   localparam int NUM_OT = 4;
   // ---------------------------------------------------------------
   // measurement sequencer
   // ---------------------------------------------------------------
   localparam logic [2:0] FIRST_CH = 3'h1;
   localparam logic [2:0] LAST_CH = 3'h6;
   localparam logic [15:0] CONV_CYCLES_DEF = 16'h0010;
endpackage

// [design/status_flag_bits.sv]
// sticky status bits: hardware sets, a read clears, set wins
module status_flag_bits #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] set,
   input wire logic clr,
   output logic [W-1:0] flags
);
   logic [W-1:0] flags_r;
   logic [W-1:0] flags_nxt;

   // a set in the clearing cycle survives, so no event is lost
   assign flags_nxt = set | (flags_r & ~{W{clr}});
   assign flags = flags_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) flags_r <= '0;
      else flags_r <= flags_nxt;
   end
endmodule

// [design/temp_alarm_status_flags.sv]
// smbus-read status flags for over-temperature and diode faults
module temp_alarm_status_flags
   import temp_alarm_pkg::*;
#(
   parameter logic [15:0] CONV_CYCLES = CONV_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [NUM_OT-1:0] ot_exceed,
   input wire logic [NUM_REMOTE-1:0] diode_inputs_open,
   input wire logic [NUM_REMOTE-1:0] diode_anode_input_at_supply,
   output logic [2:0] meas_ch,
   output logic over_temperature_alarm
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_TX   = 5'b01000,
      ST_MACK = 5'b10000
   } bus_state_t;

   // ---------------------------------------------------------------
   // line sampling and bus conditions
   // ---------------------------------------------------------------
   logic scl_q_r;
   logic sda_q_r;
   wire scl_rise = scl_in & ~scl_q_r;
   wire scl_fall = ~scl_in & scl_q_r;
   wire start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
   wire stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   // ---------------------------------------------------------------
   // status flags and read data
   // ---------------------------------------------------------------
   logic [NUM_OT-1:0] ot_flags;
   logic [NUM_REMOTE-1:0] fault_flags;
   logic [NUM_OT-1:0] ot_set;
   logic [NUM_REMOTE-1:0] fault_now;
   logic [7:0] cmd_r;
   logic rd_ot_clr;
   logic rd_fault_clr;
   logic [7:0] overtemp_status;
   logic [7:0] diode_fault_status;
   logic [7:0] rd_byte;
   logic tx_load;

   assign fault_now = diode_inputs_open | diode_anode_input_at_supply;

   // reserved positions are constant zero, nothing can write them
   always_comb begin
      overtemp_status = OVERTEMP_STATUS_RST;
      overtemp_status[OT_BIT_CH1] = ot_flags[0];
      overtemp_status[OT_BIT_CH4] = ot_flags[1];
      overtemp_status[OT_BIT_CH5] = ot_flags[2];
      overtemp_status[OT_BIT_CH6] = ot_flags[3];
      diode_fault_status = DIODE_FAULT_STATUS_RST;
      diode_fault_status[FAULT_BIT_FIRST +: NUM_REMOTE] = fault_flags;
   end

   assign rd_byte = (cmd_r == CMD_OVERTEMP_STATUS) ? overtemp_status :
                    (cmd_r == CMD_DIODE_FAULT_STATUS) ? diode_fault_status :
                    UNMAPPED_READ;
   // a read clears only the register whose byte went out
   assign rd_ot_clr = tx_load & (cmd_r == CMD_OVERTEMP_STATUS);
   assign rd_fault_clr = tx_load & (cmd_r == CMD_DIODE_FAULT_STATUS);

   status_flag_bits #(.W(NUM_OT)) u_ot_flags (
      .clk(clk),
      .rst_b(rst_b),
      .set(ot_set),
      .clr(rd_ot_clr),
      .flags(ot_flags)
   );

   status_flag_bits #(.W(NUM_REMOTE)) u_fault_flags (
      .clk(clk),
      .rst_b(rst_b),
      .set(fault_now),
      .clr(rd_fault_clr),
      .flags(fault_flags)
   );

   // ---------------------------------------------------------------
   // measurement sequencer
   // ---------------------------------------------------------------
   logic [2:0] meas_ch_r;
   logic [2:0] meas_ch_nxt;
   logic [15:0] conv_cnt_r;
   logic alarm_r;
   wire conv_end = (conv_cnt_r == CONV_CYCLES - 16'h0001);

   // next healthy channel after the current one, wrapping 6 -> 1
   always_comb begin
      logic [2:0] cand;
      meas_ch_nxt = meas_ch_r;
      cand = meas_ch_r;
      for (int i = 0; i < NUM_REMOTE; i++) begin
         cand = (cand == LAST_CH) ? FIRST_CH : cand + 3'h1;
         if (!fault_now[cand - 3'h1] && meas_ch_nxt == meas_ch_r && cand != meas_ch_r)
            meas_ch_nxt = cand;
      end
   end

   // only a completed conversion of a healthy channel can raise an over-temperature flag
   always_comb begin
      logic ok;
      ok = conv_end & ~fault_now[meas_ch_r - 3'h1];
      ot_set[0] = ok & (meas_ch_r == 3'h1) & ot_exceed[0];
      ot_set[1] = ok & (meas_ch_r == 3'h4) & ot_exceed[1];
      ot_set[2] = ok & (meas_ch_r == 3'h5) & ot_exceed[2];
      ot_set[3] = ok & (meas_ch_r == 3'h6) & ot_exceed[3];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_cnt_r <= '0;
         meas_ch_r <= FIRST_CH;
         alarm_r <= 1'b0;
      end else begin
         conv_cnt_r <= conv_end ? 16'h0000 : conv_cnt_r + 16'h0001;
         if (conv_end) meas_ch_r <= meas_ch_nxt;
         alarm_r <= |ot_flags;
      end
   end

   assign meas_ch = meas_ch_r;
   assign over_temperature_alarm = alarm_r;

   // ---------------------------------------------------------------
   // smbus target engine
   // ---------------------------------------------------------------
   bus_state_t state_r;
   logic [7:0] sh_r;
   logic [2:0] cnt_r;
   logic [1:0] byte_idx_r; // 0 address, 1 command, 2 data
   logic rw_r;
   logic mack_r;
   logic oe_r;
   logic out_r;
   // the fall that ends a start condition carries no bit, so count falls only after a rise
   logic bit_seen_r;

   wire addr_hit = (sh_r[7:1] == TARGET_ADDR);
   wire byte_done = scl_fall & bit_seen_r & (cnt_r == BIT_LAST);
   // the first data byte goes out on the fall that ends the ack of a read address
   assign tx_load = (state_r == ST_ACK) & scl_fall & rw_r & (byte_idx_r == 2'h0)
                  | (state_r == ST_MACK) & scl_fall & mack_r;

   // a falling clock moves the target; a rising clock samples the line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         bit_seen_r <= 1'b0;
         sh_r <= 8'h00;
         cnt_r <= 3'h0;
         byte_idx_r <= 2'h0;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
         out_r <= 1'b0;
         cmd_r <= 8'h00;
      end else if (start_cond) begin
         state_r <= ST_RX;
         bit_seen_r <= 1'b0;
         cnt_r <= 3'h0;
         byte_idx_r <= 2'h0;
         oe_r <= 1'b0;
      end else if (stop_cond) begin
         state_r <= ST_IDLE;
         oe_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               oe_r <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise) sh_r <= {sh_r[6:0], sda_in};
               if (scl_rise) bit_seen_r <= 1'b1;
               if (scl_fall && bit_seen_r) cnt_r <= cnt_r + 3'h1;
               if (byte_done) begin
                  if (byte_idx_r != 2'h0) begin
                     // data bytes are acked but never stored
                     if (byte_idx_r == 2'h1) cmd_r <= sh_r;
                     oe_r <= 1'b1;
                     state_r <= ST_ACK;
                  end else if (addr_hit) begin
                     rw_r <= sh_r[0];
                     oe_r <= 1'b1;
                     state_r <= ST_ACK;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  byte_idx_r <= (byte_idx_r == 2'h2) ? 2'h2 : byte_idx_r + 2'h1;
                  cnt_r <= 3'h0;
                  if (tx_load) begin
                     sh_r <= rd_byte;
                     oe_r <= ~rd_byte[7];
                     state_r <= ST_TX;
                  end else begin
                     oe_r <= 1'b0;
                     state_r <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  cnt_r <= cnt_r + 3'h1;
                  sh_r <= {sh_r[6:0], 1'b0};
                  oe_r <= (cnt_r == BIT_LAST) ? 1'b0 : ~sh_r[6];
                  if (cnt_r == BIT_LAST) state_r <= ST_MACK;
               end
            end
            ST_MACK: begin
               if (scl_rise) mack_r <= ~sda_in;
               if (scl_fall) begin
                  cnt_r <= 3'h0;
                  if (mack_r) begin
                     sh_r <= rd_byte;
                     oe_r <= ~rd_byte[7];
                     state_r <= ST_TX;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // open drain: the driven level is always low
   assign sda_out = out_r;
   assign sda_oe = oe_r;
endmodule

// [tb/temp_alarm_status_flags_monitor.sv]
// port-level checks for the status-flag block
module temp_alarm_status_flags_monitor
   import temp_alarm_pkg::*;
#(
   parameter logic [15:0] CONV_CYCLES = CONV_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [NUM_OT-1:0] ot_exceed,
   input wire logic [NUM_REMOTE-1:0] diode_inputs_open,
   input wire logic [NUM_REMOTE-1:0] diode_anode_input_at_supply,
   input wire logic [2:0] meas_ch,
   input wire logic over_temperature_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [NUM_REMOTE-1:0] flt_q;
   // fault view of the cycle in which the rotation chose its channel
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flt_q <= '0;
      end else begin
         flt_q <= diode_inputs_open | diode_anode_input_at_supply;
      end
   end
   a_sda_out_low: assert property (sda_out == 1'b0)
      else $error("sda value not zero");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in) && !scl_in)
      else $error("sda moved while scl high");
   a_ch_range: assert property (meas_ch >= FIRST_CH && meas_ch <= LAST_CH)
      else $error("channel out of range");
   a_skip_faulted: assert property ($changed(meas_ch) |-> !flt_q[meas_ch - FIRST_CH])
      else $error("faulted channel converted");
   a_conv_hold: assert property ($changed(meas_ch) |=> $stable(meas_ch))
      else $error("conversion too short");
   a_alarm_cause: assert property ($rose(over_temperature_alarm) |->
      ($past(ot_exceed) | $past(ot_exceed, 2)) != '0)
      else $error("alarm without cause");
   a_alarm_clear: assert property ($fell(over_temperature_alarm) |-> sda_oe)
      else $error("alarm cleared outside a read");
endmodule
bind temp_alarm_status_flags temp_alarm_status_flags_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
   .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .ot_exceed(ot_exceed), .diode_inputs_open(diode_inputs_open),
   .diode_anode_input_at_supply(diode_anode_input_at_supply), .meas_ch(meas_ch),
   .over_temperature_alarm(over_temperature_alarm));

// [tb/smbus_host_model.sv]
// behavioural smbus host for register reads
module smbus_host_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl = 1'b1,
   output logic sda_low = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // one half phase of four clocks keeps each scl level above three
   task automatic lv(input logic c, input logic d);
      scl = c;
      sda_low = !d;
      repeat (4) @(negedge clk);
   endtask
   // sda only moves while scl is low, except inside start and stop
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic nak);
      for (int i = 8; i >= 0; i--) begin
         lv(1'b0, i == 0 ? last : tx[i-1]);
         lv(1'b1, i == 0 ? last : tx[i-1]);
         if (i == 0) nak = sda_line;
         else rx[i-1] = sda_line;
         lv(1'b0, i == 0 ? last : tx[i-1]);
      end
   endtask
   task automatic start();
      lv(1'b0, 1'b1);
      lv(1'b1, 1'b1);
      lv(1'b1, 1'b0);
      lv(1'b0, 1'b0);
   endtask
   // read byte; nak high when the address was not answered
   task automatic read_reg(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] d,
      output logic nak);
      logic [7:0] j;
      logic n2;
      start();
      xfer({a, 1'b0}, 1'b1, j, nak);
      if (!nak) begin
         xfer(cmd, 1'b1, j, n2);
         start();
         xfer({a, 1'b1}, 1'b1, j, n2);
         xfer(8'hFF, 1'b1, d, n2);
      end
      lv(1'b0, 1'b0);
      lv(1'b1, 1'b0);
      lv(1'b1, 1'b1);
   endtask
endmodule

// [tb/temp_alarm_status_flags_tb.sv]
// self-checking bench for the status-flag block
module temp_alarm_status_flags_tb import temp_alarm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
      $display("[FAIL] %0t got %h want %h", $time, g, e); end end
   localparam logic [15:0] CONV = 16'h0004;
   localparam int WAIT = 8 * NUM_REMOTE * 4;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic scl, sda_low, sda_oe, sda_out, sda, alarm, nak;
   logic [2:0] ch;
   logic [7:0] rd;
   logic [NUM_OT-1:0] ot = '0;
   logic [NUM_REMOTE-1:0] dopen = '0;
   logic [NUM_REMOTE-1:0] dvcc = '0;
   int err_total = 0;
   int check_count = 0;
   int ot_bit [NUM_OT] = '{OT_BIT_CH1, OT_BIT_CH4, OT_BIT_CH5, OT_BIT_CH6};
   always #12.5 clk = ~clk;
   // pulled-up sda: low while either party pulls
   assign sda = !(sda_oe || sda_low);
   temp_alarm_status_flags #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .rst_b(rst_b),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .ot_exceed(ot),
      .diode_inputs_open(dopen), .diode_anode_input_at_supply(dvcc), .meas_ch(ch),
      .over_temperature_alarm(alarm));
   smbus_host_model u_host (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
   task automatic conclude();
      if (err_total == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rchk(input logic [7:0] cmd, input logic [7:0] e);
      u_host.read_reg(TARGET_ADDR, cmd, rd, nak);
      `CHK(nak, 1'b0)
      `CHK(rd, e)
   endtask
   // a hung transfer ends the run as a failure
   initial begin
      #1000000;
      err_total++;
      conclude();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      `CHK(ch, FIRST_CH)
      `CHK(alarm, 1'b0)
      `CHK(sda_oe, 1'b0)
      repeat (4) @(negedge clk);
      rchk(CMD_OVERTEMP_STATUS, OVERTEMP_STATUS_RST);
      rchk(CMD_DIODE_FAULT_STATUS, DIODE_FAULT_STATUS_RST);
      rchk(8'h07, UNMAPPED_READ);
      u_host.read_reg(TARGET_ADDR ^ 7'h01, CMD_OVERTEMP_STATUS, rd, nak);
      `CHK(nak, 1'b1)
      // faults alternate open inputs and anode at supply; flags stay sticky
      for (int n = 1; n <= NUM_REMOTE; n++) begin
         dopen[n-1] = n[0];
         dvcc[n-1] = !n[0];
         repeat (4) @(negedge clk);
         dopen = '0;
         dvcc = '0;
         rchk(CMD_DIODE_FAULT_STATUS, 8'h01 << n);
      end
      for (int i = 0; i < NUM_OT; i++) begin
         ot[i] = 1'b1;
         repeat (WAIT) @(negedge clk);
         ot = '0;
         `CHK(alarm, 1'b1)
         rchk(CMD_OVERTEMP_STATUS, 8'h01 << ot_bit[i]);
         rchk(CMD_OVERTEMP_STATUS, 8'h00);
         `CHK(alarm, 1'b0)
      end
      // channel 4 faulted while over its limit is never converted
      dopen[3] = 1'b1;
      ot[1] = 1'b1;
      repeat (WAIT) @(negedge clk);
      ot = '0;
      rchk(CMD_OVERTEMP_STATUS, 8'h00);
      rchk(CMD_DIODE_FAULT_STATUS, 8'h10);
      dopen = '0;
      conclude();
   end
endmodule
